//--- smb_pkg.sv
// Shared constants and types for the two-wire bus control and status flag block.
`default_nettype none
package smb_pkg;
    // Register addresses on the special-function register port.
    localparam logic [7:0] SMB_CTRL_ADDR = 8'hc0;
    localparam logic [7:0] SMB_DATA_ADDR = 8'hc2;

    // Bit positions inside bus_control_status.
    localparam int unsigned SMB_BIT_MASTER  = 7;
    localparam int unsigned SMB_BIT_TXDIR   = 6;
    localparam int unsigned SMB_BIT_STA     = 5;
    localparam int unsigned SMB_BIT_STO     = 4;
    localparam int unsigned SMB_BIT_ACK_REQUEST_FLAG   = 3;
    localparam int unsigned SMB_BIT_ARBITRATION_LOST_FLAG = 2;
    localparam int unsigned SMB_BIT_ACK     = 1;
    localparam int unsigned SMB_BIT_SI      = 0;

    // Values after reset.
    localparam logic [7:0] SMB_CTRL_RESET = 8'h00;
    localparam logic [7:0] SMB_DATA_RESET = 8'h00;
    localparam logic [1:0] SMB_SYNC_RESET = 2'h3;

    // Bit position counts of one byte frame.
    localparam logic [3:0] SMB_LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] SMB_ACK_BIT       = 4'h8;

    // Half period of the generated serial clock; a least time, so it rounds up.
    localparam int unsigned SMB_CLK_MHZ  = 250;
    localparam int unsigned SMB_HALF_NS  = 5000;
    localparam int unsigned SMB_HALF_CYC = (SMB_HALF_NS * SMB_CLK_MHZ + 999) / 1000;
    localparam int unsigned SMB_TICK_W   = 11;
    localparam logic [SMB_TICK_W-1:0] SMB_TICK_LAST = SMB_TICK_W'(SMB_HALF_CYC - 1);
    localparam logic [SMB_TICK_W-1:0] SMB_TICK_RESET = 11'h000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_RSTART,
        ST_XFER,
        ST_HOLD,
        ST_STOP,
        ST_SKIP
    } smb_state_t;
endpackage
`default_nettype wire

//--- smb_line_if.sv
// Carrier of synchronised bus line levels, bus conditions and the bit timing tick.
`default_nettype none
interface smb_line_if;
    logic scl;
    logic sda;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    logic tick;

    modport mon  (output scl, output sda, output start_det, output stop_det,
                  output scl_rise, output scl_fall);
    modport tgen (output tick);
    modport core (input scl, input sda, input start_det, input stop_det,
                  input scl_rise, input scl_fall, input tick);
endinterface
`default_nettype wire

//--- smb_line_mon.sv
// Pin synchroniser and START, STOP and clock edge detector for the bus lines.
`default_nettype none
module smb_line_mon
    import smb_pkg::*;
(
    input  wire logic sys_clk_in,
    input  wire logic srst_in,
    input  wire logic scl_in,
    input  wire logic sda_in,
    smb_line_if.mon   ln
);
    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic       scl_h;
        logic       sda_h;
        logic       start;
        logic       stop;
        logic       rise;
        logic       fall;
    } smb_mon_t;

    smb_mon_t r_reg;
    smb_mon_t r_next;

    // Stage 0 of each synchroniser feeds stage 1 only; detection looks at stage 1 onward.
    always_comb begin
        r_next       = r_reg;
        r_next.scl_s = {r_reg.scl_s[0], scl_in};
        r_next.sda_s = {r_reg.sda_s[0], sda_in};
        r_next.scl_h = r_reg.scl_s[1];
        r_next.sda_h = r_reg.sda_s[1];
        r_next.start = r_reg.scl_s[1] && r_reg.scl_h && r_reg.sda_h && !r_reg.sda_s[1];
        r_next.stop  = r_reg.scl_s[1] && r_reg.scl_h && !r_reg.sda_h && r_reg.sda_s[1];
        r_next.rise  = r_reg.scl_s[1] && !r_reg.scl_h;
        r_next.fall  = !r_reg.scl_s[1] && r_reg.scl_h;
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            r_reg       <= '0;
            r_reg.scl_s <= SMB_SYNC_RESET;
            r_reg.sda_s <= SMB_SYNC_RESET;
            r_reg.scl_h <= SMB_SYNC_RESET[0];
            r_reg.sda_h <= SMB_SYNC_RESET[0];
        end else begin
            r_reg <= r_next;
        end
    end

    assign ln.scl       = r_reg.scl_h;
    assign ln.sda       = r_reg.sda_h;
    assign ln.start_det = r_reg.start;
    assign ln.stop_det  = r_reg.stop;
    assign ln.scl_rise  = r_reg.rise;
    assign ln.scl_fall  = r_reg.fall;
endmodule
`default_nettype wire

//--- smb_tick_gen.sv
// Free-running half-bit tick that paces the generated serial clock.
`default_nettype none
module smb_tick_gen
    import smb_pkg::*;
(
    input  wire logic sys_clk_in,
    input  wire logic srst_in,
    smb_line_if.tgen  tk
);
    typedef struct packed {
        logic [SMB_TICK_W-1:0] cnt;
        logic                  tick;
    } smb_tick_t;

    smb_tick_t r_reg;
    smb_tick_t r_next;

    always_comb begin
        r_next      = r_reg;
        r_next.tick = (r_reg.cnt == SMB_TICK_LAST);
        if (r_reg.cnt == SMB_TICK_LAST) begin
            r_next.cnt = SMB_TICK_RESET;
        end else begin
            r_next.cnt = r_reg.cnt + 11'h001;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            r_reg.cnt  <= SMB_TICK_RESET;
            r_reg.tick <= 1'b0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign tk.tick = r_reg.tick;
endmodule
`default_nettype wire

//--- smb_ctrl_flags.sv
// Control and status flag logic with byte engine for the two-wire bus controller.
`default_nettype none
module smb_ctrl_flags
    import smb_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       srst_in,
    input  wire logic [7:0] sfr_addr_in,
    input  wire logic       sfr_wr_in,
    input  wire logic [7:0] sfr_wmask_in,
    input  wire logic [7:0] sfr_wdata_in,
    input  wire logic       sfr_rd_in,
    output logic      [7:0] sfr_rdata_out,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            scl_out,
    output logic            scl_oe_out,
    output logic            sda_out,
    output logic            sda_oe_out,
    output logic            target_inhibit_out
);
    typedef struct packed {
        smb_state_t st;
        logic       master;
        logic       transmit_direction_flag;
        logic       start_request_flag;
        logic       stop_request_flag;
        logic       ack_request_flag;
        logic       arbitration_lost_flag;
        logic       ack;
        logic       si;
        logic       ack_written;
        logic       data_written;
        logic       inhibit;
        logic       busy;
        logic       is_addr;
        logic       rx_dir;
        logic       pend_ack;
        logic       phase;
        logic       scl_oe;
        logic       sda_oe;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic [7:0] data;
        logic [7:0] rdata;
        logic       zero;
    } smb_core_t;

    smb_core_t  r_reg;
    smb_core_t  r_next;
    logic [7:0] ctrl_vec;
    logic       wr_ctrl;
    logic       wr_data;
    logic       do_sample;
    logic       do_advance;

    smb_line_if line_bus ();

    smb_line_mon u_line_mon (
        .sys_clk_in (sys_clk_in),
        .srst_in    (srst_in),
        .scl_in     (scl_in),
        .sda_in     (sda_in),
        .ln         (line_bus.mon)
    );

    smb_tick_gen u_tick_gen (
        .sys_clk_in (sys_clk_in),
        .srst_in    (srst_in),
        .tk         (line_bus.tgen)
    );

    // Losing arbitration drops the controller role and SDA; SCL stays low while the flag is up.
    function automatic smb_core_t lose_arb(input smb_core_t c);
        smb_core_t t;
        t          = c;
        t.arbitration_lost_flag  = 1'b1;
        t.si       = 1'b1;
        t.master   = 1'b0;
        t.transmit_direction_flag   = 1'b0;
        t.st       = ST_HOLD;
        t.scl_oe   = 1'b1;
        t.sda_oe   = 1'b0;
        t.phase    = 1'b0;
        t.pend_ack = 1'b0;
        return t;
    endfunction

    always_comb begin
        r_next     = r_reg;
        do_sample  = 1'b0;
        do_advance = 1'b0;
        ctrl_vec   = {r_reg.master, r_reg.transmit_direction_flag, r_reg.start_request_flag, r_reg.stop_request_flag,
                      r_reg.ack_request_flag, r_reg.arbitration_lost_flag, r_reg.ack, r_reg.si};
        wr_ctrl    = sfr_wr_in && (sfr_addr_in == SMB_CTRL_ADDR);
        wr_data    = sfr_wr_in && (sfr_addr_in == SMB_DATA_ADDR);

        if (sfr_rd_in) begin
            if (sfr_addr_in == SMB_CTRL_ADDR) begin
                r_next.rdata = ctrl_vec;
            end else if (sfr_addr_in == SMB_DATA_ADDR) begin
                r_next.rdata = r_reg.data;
            end else begin
                r_next.rdata = 8'h00;
            end
        end

        // Software writes come first so that any hardware set below overrides them.
        // Role, direction, ack request and arbitration bits take no write.
        if (wr_ctrl) begin
            if (sfr_wmask_in[SMB_BIT_STA]) begin
                r_next.start_request_flag = sfr_wdata_in[SMB_BIT_STA];
            end
            if (sfr_wmask_in[SMB_BIT_STO]) begin
                r_next.stop_request_flag = sfr_wdata_in[SMB_BIT_STO];
            end
            if (sfr_wmask_in[SMB_BIT_ACK]) begin
                r_next.ack         = sfr_wdata_in[SMB_BIT_ACK];
                r_next.ack_written = 1'b1;
            end
            if (sfr_wmask_in[SMB_BIT_SI]) begin
                r_next.si = sfr_wdata_in[SMB_BIT_SI];
                if (!sfr_wdata_in[SMB_BIT_SI]) begin
                    r_next.arbitration_lost_flag = 1'b0;
                end
            end
        end
        if (wr_data) begin
            r_next.data         = sfr_wdata_in;
            r_next.data_written = 1'b1;
        end

        if (line_bus.start_det) begin
            r_next.busy = 1'b1;
        end
        if (line_bus.stop_det) begin
            r_next.busy = 1'b0;
        end

        case (r_reg.st)
            ST_IDLE: begin
                r_next.scl_oe = 1'b0;
                r_next.sda_oe = 1'b0;
                // A pending interrupt stalls any new START as well.
                if (r_reg.start_request_flag && !r_reg.busy && !r_reg.si && line_bus.tick) begin
                    r_next.sda_oe = 1'b1;
                    r_next.master = 1'b1;
                    r_next.transmit_direction_flag = 1'b1;
                    r_next.phase  = 1'b0;
                    r_next.st     = ST_START;
                end
            end
            ST_START: begin
                if (line_bus.tick) begin
                    r_next.scl_oe   = 1'b1;
                    r_next.si       = 1'b1;
                    r_next.is_addr  = 1'b1;
                    r_next.pend_ack = 1'b0;
                    r_next.st       = ST_HOLD;
                end
            end
            ST_RSTART: begin
                if (!r_reg.phase) begin
                    r_next.sda_oe = 1'b0;
                    if (line_bus.tick) begin
                        r_next.scl_oe = 1'b0;
                        r_next.phase  = 1'b1;
                    end
                end else if (line_bus.tick) begin
                    if (!line_bus.scl) begin
                        r_next = lose_arb(r_next);
                    end else begin
                        r_next.sda_oe = 1'b1;
                        r_next.transmit_direction_flag = 1'b1;
                        r_next.phase  = 1'b0;
                        r_next.st     = ST_START;
                    end
                end
            end
            ST_STOP: begin
                if (!r_reg.phase) begin
                    r_next.sda_oe = 1'b1;
                    if (line_bus.tick) begin
                        r_next.scl_oe = 1'b0;
                        r_next.phase  = 1'b1;
                    end
                end else if (line_bus.tick) begin
                    if (!line_bus.scl) begin
                        r_next = lose_arb(r_next);
                    end else begin
                        // A start request still set restarts from idle once the bus frees.
                        r_next.sda_oe = 1'b0;
                        r_next.stop_request_flag    = 1'b0;
                        r_next.master = 1'b0;
                        r_next.transmit_direction_flag = 1'b0;
                        r_next.phase  = 1'b0;
                        r_next.st     = ST_IDLE;
                    end
                end
            end
            ST_XFER: begin
                if (r_reg.master) begin
                    if (!r_reg.phase) begin
                        if (line_bus.tick) begin
                            r_next.scl_oe = 1'b0;
                            r_next.phase  = 1'b1;
                        end
                    end else if (line_bus.tick && line_bus.scl) begin
                        // Waiting for SCL high lets a stretching target slow the bit.
                        do_sample     = 1'b1;
                        do_advance    = 1'b1;
                        r_next.scl_oe = 1'b1;
                        r_next.phase  = 1'b0;
                    end
                end else begin
                    r_next.scl_oe = 1'b0;
                    if (line_bus.scl_rise) begin
                        do_sample    = 1'b1;
                        r_next.phase = 1'b1;
                    end
                    if (line_bus.scl_fall && r_reg.phase) begin
                        do_advance   = 1'b1;
                        r_next.phase = 1'b0;
                    end
                end
            end
            ST_HOLD: begin
                r_next.scl_oe = 1'b1;
                if (r_reg.pend_ack) begin
                    r_next.sda_oe = r_reg.ack_written && r_reg.ack;
                end
                if (!r_reg.si) begin
                    r_next.phase = 1'b0;
                    if (r_reg.pend_ack) begin
                        r_next.pend_ack = 1'b0;
                        r_next.bit_cnt  = SMB_ACK_BIT;
                        r_next.scl_oe   = r_reg.master;
                        r_next.st       = ST_XFER;
                    end else if (r_reg.master) begin
                        if (r_reg.stop_request_flag) begin
                            r_next.st = ST_STOP;
                        end else if (r_reg.start_request_flag && !r_reg.is_addr) begin
                            r_next.st = ST_RSTART;
                        end else begin
                            r_next.transmit_direction_flag       = r_reg.data_written || r_reg.is_addr;
                            r_next.shreg        = r_reg.data;
                            r_next.bit_cnt      = 4'h0;
                            r_next.data_written = 1'b0;
                            r_next.sda_oe       = r_next.transmit_direction_flag && !r_reg.data[7];
                            r_next.st           = ST_XFER;
                        end
                    end else if (r_reg.transmit_direction_flag && r_reg.ack) begin
                        r_next.shreg   = r_reg.data;
                        r_next.bit_cnt = 4'h0;
                        r_next.sda_oe  = !r_reg.data[7];
                        r_next.scl_oe  = 1'b0;
                        r_next.st      = ST_XFER;
                    end else begin
                        r_next.scl_oe = 1'b0;
                        r_next.sda_oe = 1'b0;
                        r_next.st     = ST_SKIP;
                    end
                end
            end
            ST_SKIP: begin
                r_next.scl_oe = 1'b0;
                r_next.sda_oe = 1'b0;
                // Waiting for a free bus keeps a beaten controller off the wire.
                if (!r_reg.busy) begin
                    r_next.st = ST_IDLE;
                end
            end
            default: begin
                r_next.st = ST_IDLE;
            end
        endcase

        if (do_sample) begin
            if (r_reg.bit_cnt < SMB_ACK_BIT) begin
                r_next.shreg = {r_reg.shreg[6:0], line_bus.sda};
                if (r_reg.transmit_direction_flag && !r_reg.sda_oe && !line_bus.sda) begin
                    r_next = lose_arb(r_next);
                end
            end else if (r_reg.transmit_direction_flag) begin
                r_next.ack = !line_bus.sda;
            end
        end

        if (do_advance && r_next.st == ST_XFER) begin
            if (r_reg.bit_cnt == SMB_LAST_DATA_BIT) begin
                if (r_reg.transmit_direction_flag) begin
                    r_next.bit_cnt = SMB_ACK_BIT;
                    r_next.sda_oe  = 1'b0;
                end else begin
                    // The receiver interrupt comes before the acknowledge bit.
                    r_next.si          = 1'b1;
                    r_next.ack_request_flag       = 1'b1;
                    r_next.ack_written = 1'b0;
                    r_next.pend_ack    = 1'b1;
                    r_next.sda_oe      = 1'b0;
                    r_next.st          = ST_HOLD;
                    if (r_reg.is_addr && !r_reg.master) begin
                        r_next.start_request_flag    = 1'b1;
                        r_next.rx_dir = r_next.shreg[0];
                    end
                end
            end else if (r_reg.bit_cnt == SMB_ACK_BIT) begin
                r_next.ack_request_flag   = 1'b0;
                r_next.sda_oe  = 1'b0;
                r_next.is_addr = 1'b0;
                r_next.bit_cnt = 4'h0;
                if (r_reg.transmit_direction_flag) begin
                    r_next.si = 1'b1;
                    r_next.st = ST_HOLD;
                end else if (r_reg.is_addr && !r_reg.master && !r_reg.sda_oe) begin
                    r_next.inhibit = 1'b1;
                    r_next.st      = ST_SKIP;
                end else if (r_reg.is_addr && !r_reg.master && r_reg.rx_dir) begin
                    r_next.transmit_direction_flag = 1'b1;
                    r_next.shreg  = r_reg.data;
                    r_next.sda_oe = !r_reg.data[7];
                end else if (r_reg.master && r_reg.stop_request_flag) begin
                    r_next.st = ST_STOP;
                end else if (r_reg.master && r_reg.start_request_flag) begin
                    r_next.st = ST_RSTART;
                end
            end else begin
                r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
                r_next.sda_oe  = r_reg.transmit_direction_flag && !r_next.shreg[7];
            end
        end

        // Bus conditions seen on the lines take precedence over the byte engine.
        if (line_bus.stop_det) begin
            if (r_reg.master && r_reg.st != ST_STOP) begin
                r_next     = lose_arb(r_next);
                r_next.stop_request_flag = 1'b1;
            end else if (!r_reg.master && r_reg.st != ST_IDLE && r_reg.st != ST_SKIP) begin
                r_next.stop_request_flag    = 1'b1;
                r_next.si     = 1'b1;
                r_next.scl_oe = 1'b0;
                r_next.sda_oe = 1'b0;
                r_next.st     = ST_IDLE;
            end
        end
        if (line_bus.start_det) begin
            if (r_reg.master) begin
                if (r_reg.st != ST_START && !r_reg.start_request_flag) begin
                    r_next = lose_arb(r_next);
                end
            end else begin
                r_next.inhibit  = 1'b0;
                r_next.transmit_direction_flag   = 1'b0;
                r_next.is_addr  = 1'b1;
                r_next.bit_cnt  = 4'h0;
                r_next.phase    = 1'b0;
                r_next.pend_ack = 1'b0;
                r_next.scl_oe   = 1'b0;
                r_next.sda_oe   = 1'b0;
                r_next.st       = ST_XFER;
            end
        end
    end

    // Hardware sets are applied after software writes above, so a set wins.
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            r_reg    <= '0;
            r_reg.st <= ST_IDLE;
            {r_reg.master, r_reg.transmit_direction_flag, r_reg.start_request_flag, r_reg.stop_request_flag,
             r_reg.ack_request_flag, r_reg.arbitration_lost_flag, r_reg.ack, r_reg.si} <= SMB_CTRL_RESET;
            r_reg.data <= SMB_DATA_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign sfr_rdata_out      = r_reg.rdata;
    assign scl_out            = r_reg.zero;
    assign sda_out            = r_reg.zero;
    assign scl_oe_out         = r_reg.scl_oe;
    assign sda_oe_out         = r_reg.sda_oe;
    assign target_inhibit_out = r_reg.inhibit;
endmodule
`default_nettype wire

//--- smb_flags_props.sv
// Port assertions for the bus control and status flag block.
`default_nettype none
module smb_flags_props
    import smb_pkg::*;
(
    input wire logic       sys_clk_in,
    input wire logic       srst_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic       sfr_wr_in,
    input wire logic [7:0] sfr_wmask_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic       sfr_rd_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic       scl_in,
    input wire logic       scl_out,
    input wire logic       scl_oe_out,
    input wire logic       sda_out,
    input wire logic       sda_oe_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);
    wire logic rd_c = sfr_rd_in && sfr_addr_in == SMB_CTRL_ADDR;
    wire logic wr_c = sfr_wr_in && sfr_addr_in == SMB_CTRL_ADDR;
    sequence s_ro;
        rd_c ##1 (wr_c && sfr_wmask_in[7:6] == 2'h3 && sfr_wdata_in[7:6] == 2'h3
            && sfr_rdata_out[7:6] == 2'h0) ##1 rd_c;
    endsequence
    sequence s_clr_si;
        wr_c && sfr_wmask_in[0] && !sfr_wdata_in[0] ##1 rd_c;
    endsequence
    reset_quiet_a: assert property (disable iff (1'b0) srst_in |=> !scl_oe_out
        && !sda_oe_out && sfr_rdata_out == 8'h00) else $error("reset outputs");
    unmapped_rd_a: assert property (sfr_rd_in && sfr_addr_in != SMB_CTRL_ADDR
        && sfr_addr_in != SMB_DATA_ADDR |=> sfr_rdata_out == 8'h00) else $error("unmapped");
    rdata_hold_a: assert property (!sfr_rd_in |=> $stable(sfr_rdata_out))
        else $error("rdata moved");
    drive_low_a: assert property (!scl_out && !sda_out) else $error("line drive high");
    // Counts from a START drive on a high SCL to the first SCL pull; a half bit must suffice.
    logic        start_arm;
    logic [10:0] start_cnt;
    always_ff @(posedge sys_clk_in) begin
        if (srst_in || scl_oe_out || !sda_oe_out) begin
            start_arm <= 1'b0;
            start_cnt <= 11'h000;
        end else if ($rose(sda_oe_out) && scl_in) begin
            start_arm <= 1'b1;
            start_cnt <= 11'h000;
        end else if (start_arm && start_cnt != 11'h7ff) begin
            start_cnt <= start_cnt + 11'h001;
        end
    end
    si_holds_scl_a: assert property (rd_c && !sfr_wr_in
        ##1 sfr_rdata_out[0] |-> scl_oe_out) else $error("scl free while flag set");
    start_clk_a: assert property (start_arm |-> start_cnt < 11'h514)
        else $error("no clock after start");
    ro_bits_a: assert property (s_ro |=> sfr_rdata_out[7:6] == 2'h0)
        else $error("read-only bits written");
    arb_clear_a: assert property (s_clr_si |=> !sfr_rdata_out[2])
        else $error("arbitration flag kept");
endmodule
bind smb_ctrl_flags smb_flags_props chk_u (.sys_clk_in, .srst_in, .sfr_addr_in, .sfr_wr_in,
    .sfr_wmask_in, .sfr_wdata_in, .sfr_rd_in, .sfr_rdata_out, .scl_in, .scl_out,
    .scl_oe_out, .sda_out, .sda_oe_out);
`default_nettype wire

//--- smb_target_model.sv
// Behavioural bus target that acknowledges the first byte after each START on request.
`default_nettype none
module smb_target_model (
    input  wire logic scl_line_in,
    input  wire logic sda_line_in,
    input  wire logic ack_en_in,
    output var logic  sda_pull_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int bits = 0;
    initial sda_pull_out = 1'b0;
    // A START restarts the count; counting the wire keeps pace with a stretched clock.
    // The check waits a moment so that SDA moving with a falling SCL is not taken for a START.
    always @(negedge sda_line_in) #1 if (scl_line_in) bits = 0;
    always @(posedge scl_line_in) bits = bits + 1;
    always @(negedge scl_line_in) sda_pull_out = ack_en_in && bits == 8;
endmodule
`default_nettype wire

//--- smb_control_status_flags_test.sv
// Self-checking bench for the bus control and status flag block.
`default_nettype none
module smb_control_status_flags_test
    import smb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rst, wr, rd, ack_en, scl_oe, sda_oe, pull, jam, target_inhibit;
    logic [7:0] addr, mask, wdat, rdat, r;
    wire logic  scl_l = !scl_oe;
    wire logic  sda_l = !(sda_oe || pull || jam);
    int         bad_count = 0;
    int         checked = 0;
    smb_ctrl_flags dut_u (.sys_clk_in(clk), .srst_in(rst), .sfr_addr_in(addr),
        .sfr_wr_in(wr), .sfr_wmask_in(mask), .sfr_wdata_in(wdat), .sfr_rd_in(rd),
        .sfr_rdata_out(rdat), .scl_in(scl_l), .sda_in(sda_l), .scl_out(),
        .scl_oe_out(scl_oe), .sda_out(), .sda_oe_out(sda_oe), .target_inhibit_out(target_inhibit));
    smb_target_model tgt_u (.scl_line_in(scl_l), .sda_line_in(sda_l),
        .ack_en_in(ack_en), .sda_pull_out(pull));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] d);
        addr = a;
        mask = m;
        wdat = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        r = rdat;
    endtask
    task automatic wait_bit(input int b, input logic v);
        for (int i = 0; i < 20000; i++) begin
            rreg(SMB_CTRL_ADDR);
            if (r[b] === v) return;
            @(negedge clk);
        end
        bad_count++;
        tally_and_finish();
    endtask
    task automatic tally_and_finish();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        {rst, wr, rd, ack_en, jam, addr, mask, wdat} = {5'h12, 24'h000000};
        repeat (16) @(negedge clk);
        rst = 1'b0;
        rreg(SMB_CTRL_ADDR);
        chk(r, SMB_CTRL_RESET);
        wreg(SMB_CTRL_ADDR, 8'hcc, 8'hff);
        rreg(SMB_CTRL_ADDR);
        chk(r, 8'h00);
        wreg(SMB_CTRL_ADDR, 8'h20, 8'h20);
        wait_bit(0, 1'b1);
        chk(r, 8'he1);
        chk({7'h00, scl_oe}, 8'h01);
        @(negedge clk);
        rreg(8'h55);
        chk(r, 8'h00);
        wreg(SMB_DATA_ADDR, 8'hff, 8'ha4);
        @(negedge clk);
        wreg(SMB_CTRL_ADDR, 8'h21, 8'h00);
        wait_bit(0, 1'b1);
        chk(r & 8'h82, 8'h82);
        wreg(SMB_CTRL_ADDR, 8'h11, 8'h10);
        wait_bit(7, 1'b0);
        chk(r & 8'h11, 8'h00);
        ack_en = 1'b0;
        wreg(SMB_CTRL_ADDR, 8'h20, 8'h20);
        wait_bit(0, 1'b1);
        wreg(SMB_DATA_ADDR, 8'hff, 8'ha5);
        @(negedge clk);
        wreg(SMB_CTRL_ADDR, 8'h21, 8'h00);
        wait_bit(0, 1'b1);
        chk(r & 8'h82, 8'h80);
        // Holding SDA low under a transmitted one forces an arbitration loss.
        wreg(SMB_DATA_ADDR, 8'hff, 8'hff);
        jam = 1'b1;
        @(negedge clk);
        wreg(SMB_CTRL_ADDR, 8'h01, 8'h00);
        wait_bit(0, 1'b1);
        chk(r, 8'h05);
        chk({7'h00, scl_oe}, 8'h01);
        jam = 1'b0;
        wreg(SMB_CTRL_ADDR, 8'h01, 8'h00);
        rreg(SMB_CTRL_ADDR);
        chk(r, 8'h00);
        chk({7'h00, target_inhibit}, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
